// ===== logic/cmpc_pkg.sv
// Functional notes
// - Once lock is 1, the whole control word, lock included, ignores writes.
// - Lock bit 31 is set once by software; only system reset clears it.
// - With a valid blanking source, output is result AND NOT blanking signal.
// - Mode 2'b00 is fastest and highest power; 2'b11 is slowest and lowest.
// - Bit 30 mirrors the comparator output after polarity and blanking, through two flops.
// - Polarity and pin routing work without the bus clock.
// - Register interface is synchronous to the peripheral bus clock.
// - Each comparator output drives its own external interrupt line.
// - Shared scaler stays powered while either scaler enable bit 23 is set.
// - Output reaches internal destinations and pins at the same time.
// - Output is offered to a timer input channel; the timer picks it.
// - Hysteresis setting includes a choice with no hysteresis.
// - Polarity bit 15 passes result when 0, inverts it when 1.
// - Blanking 000 none; 001, 010, 100, 101 pick timer compares; rest reserved.
// - Bit 0 disables the comparator when 0, enables it when 1.
package cmpc_pkg;
   // ==========================================================
   // Bus and register map
   localparam int          ADDR_W      = 12;
   localparam logic [11:0] OFS_CS0     = 12'h000;
   localparam logic [11:0] OFS_CS1     = 12'h004;
   localparam logic [31:0] CS_RESET    = 32'h0000_0000;
   // Bits that software may write while unlocked
   localparam logic [31:0] CS_WR_MASK  = 32'h80df_887d;
   // ==========================================================
   // Field positions
   localparam int BIT_LOCK    = 31;
   localparam int BIT_MIRROR  = 30;
   localparam int BIT_SCALER  = 23;
   localparam int BIT_BRIDGE  = 22;
   localparam int BLK_LSB     = 18;
   localparam int HYST_LSB    = 16;
   localparam int BIT_INVERT  = 15;
   localparam int BIT_SWITCH  = 11;
   localparam int MSEL_LSB    = 4;
   localparam int MODE_LSB    = 2;
   localparam int BIT_ON      = 0;
   // ==========================================================
   // Blanking source codes, hysteresis off and fast mode codes
   localparam logic [2:0] BLK_NONE = 3'h0;
   localparam logic [2:0] BLK_SRC0 = 3'h1;
   localparam logic [2:0] BLK_SRC1 = 3'h2;
   localparam logic [2:0] BLK_SRC2 = 3'h4;
   localparam logic [2:0] BLK_SRC3 = 3'h5;
   localparam logic [1:0] HYST_OFF = 2'h0;
   localparam logic [1:0] MODE_FAST = 2'h0;

   // Analogue control bundle for one comparator
   typedef struct packed {
      logic       comparator_on;
      logic [1:0] speed_power_mode;
      logic [1:0] hysteresis_level;
      logic [2:0] inverting_input_select;
      logic       input_pin_switch;
   } cmpc_ctrl_t;
endpackage : cmpc_pkg

// ===== logic/cmpc_out_path.sv
`timescale 1ns/1ps
// Clockless output conditioning for one comparator
module cmpc_out_path
   import cmpc_pkg::*;
(
   input  wire logic       raw_result,
   input  wire logic       output_invert,
   input  wire logic [2:0] blanking_select,
   input  wire logic [3:0] blank_src,
   output logic            result
);
   logic blank;
   logic polar;

   // ==========================================================
   // Blanking source choice; reserved codes blank nothing
   always_comb begin
      unique case (blanking_select)
         BLK_SRC0: blank = blank_src[0];
         BLK_SRC1: blank = blank_src[1];
         BLK_SRC2: blank = blank_src[2];
         BLK_SRC3: blank = blank_src[3];
         default:  blank = 1'b0;
      endcase
   end

   // No flop here so deep sleep keeps the path alive
   assign polar  = raw_result ^ output_invert;
   assign result = polar & ~blank;
endmodule : cmpc_out_path

// ===== logic/cmpc_top.sv
`timescale 1ns/1ps
// Two-comparator control, status and output conditioning
module cmpc_top
   import cmpc_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [1:0]        cmp_raw,
   input  wire logic [3:0]        blank_src,
   output logic [1:0]             cmp_pin_o,
   output logic [1:0]             cmp_timer_o,
   output logic [1:0]             cmp_external_interrupt_controller_o,
   output cmpc_ctrl_t [1:0]       cmp_ctrl_o,
   output logic                   scaler_enable_o,
   output logic                   bridge_enable_o
);
   logic [31:0] cs_q [2];
   logic [31:0] cs_d [2];
   logic [1:0]  final_out;
   logic [1:0]  mir_meta_q;
   logic [1:0]  mir_q;
   logic [31:0] prdata_d;
   logic        pready_d;
   logic        pslverr_d;
   logic        hit0;
   logic        hit1;
   logic        wr_acc;

   // ==========================================================
   // Output paths, one per comparator
   for (genvar i = 0; i < 2; i++) begin : g_path
      cmpc_out_path u_path (
         .raw_result      (cmp_raw[i]),
         .output_invert   (cs_q[i][BIT_INVERT]),
         .blanking_select (cs_q[i][BLK_LSB +: 3]),
         .blank_src       (blank_src),
         .result          (final_out[i])
      );
   end

   // Same signal fans out to pin, timer and interrupt line at once;
   // these stay combinational so they work without the bus clock
   assign cmp_pin_o   = final_out;
   assign cmp_timer_o = final_out;
   assign cmp_external_interrupt_controller_o  = final_out;

   // ==========================================================
   // Mirror synchroniser: result is asynchronous to the bus clock
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         mir_meta_q <= 2'h0;
         mir_q      <= 2'h0;
      end else begin
         mir_meta_q <= final_out;
         mir_q      <= mir_meta_q;
      end
   end

   // ==========================================================
   // Bus decode
   assign hit0   = (paddr == OFS_CS0);
   assign hit1   = (paddr == OFS_CS1);
   assign wr_acc = psel && penable && pwrite && pready;

   // Register next values; lock freezes the whole word
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cs_d[i] = cs_q[i];
      end
      if (wr_acc && hit0 && !cs_q[0][BIT_LOCK]) begin
         cs_d[0] = pwdata & CS_WR_MASK;
      end
      if (wr_acc && hit1 && !cs_q[1][BIT_LOCK]) begin
         cs_d[1] = pwdata & CS_WR_MASK;
      end
   end

   // Read data, ready and error prepared in the setup cycle
   always_comb begin
      prdata_d  = 32'h0000_0000;
      pready_d  = psel && !penable;
      pslverr_d = 1'b0;
      if (psel && !penable) begin
         if (hit0) begin
            prdata_d             = cs_q[0];
            prdata_d[BIT_MIRROR] = mir_q[0];
         end else if (hit1) begin
            prdata_d             = cs_q[1];
            prdata_d[BIT_MIRROR] = mir_q[1];
         end else begin
            pslverr_d = 1'b1; // Unmapped: zero data with error
         end
      end
      // Locked targets still answer cleanly
   end

   // ==========================================================
   // Registers on the bus clock
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cs_q[0]         <= CS_RESET;
         cs_q[1]         <= CS_RESET;
         prdata          <= 32'h0000_0000;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
         scaler_enable_o <= 1'b0;
         bridge_enable_o <= 1'b0;
         cmp_ctrl_o      <= '0;
      end else begin
         cs_q[0]         <= cs_d[0];
         cs_q[1]         <= cs_d[1];
         prdata          <= prdata_d;
         pready          <= pready_d;
         pslverr         <= pslverr_d;
         // Shared scaler: off only when both enables are clear
         scaler_enable_o <= cs_d[0][BIT_SCALER] | cs_d[1][BIT_SCALER];
         bridge_enable_o <= cs_d[0][BIT_BRIDGE] | cs_d[1][BIT_BRIDGE];
         for (int i = 0; i < 2; i++) begin
            cmp_ctrl_o[i].comparator_on          <= cs_d[i][BIT_ON];
            cmp_ctrl_o[i].speed_power_mode       <= cs_d[i][MODE_LSB +: 2];
            cmp_ctrl_o[i].hysteresis_level       <= cs_d[i][HYST_LSB +: 2];
            cmp_ctrl_o[i].inverting_input_select <= cs_d[i][MSEL_LSB +: 3];
            cmp_ctrl_o[i].input_pin_switch       <= cs_d[i][BIT_SWITCH];
         end
      end
   end

   // ==========================================================
   // Checks
   logic [1:0] expect_out;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         expect_out[i] = (cmp_raw[i] ^ cs_q[i][BIT_INVERT])
                         & ~((cs_q[i][BLK_LSB +: 3] == BLK_SRC0) & blank_src[0]
                           | (cs_q[i][BLK_LSB +: 3] == BLK_SRC1) & blank_src[1]
                           | (cs_q[i][BLK_LSB +: 3] == BLK_SRC2) & blank_src[2]
                           | (cs_q[i][BLK_LSB +: 3] == BLK_SRC3) & blank_src[3]);
      end
   end

   sequence locked_wr0;
      psel && !penable && pwrite && hit0 && cs_q[0][BIT_LOCK];
   endsequence
   sequence clean_ack;
      pready && !pslverr;
   endsequence

   lock_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      cs_q[0][BIT_LOCK] |=> $stable(cs_q[0]))
      else $error("locked word 0 changed");
   lock_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      cs_q[1][BIT_LOCK] |=> cs_q[1][BIT_LOCK] && $stable(cs_q[1]))
      else $error("lock 1 cleared or word changed");
   blank_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmp_timer_o == expect_out)
      else $error("conditioned output wrong");
   mode_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ##1 cmp_ctrl_o[0].speed_power_mode == $past(cs_d[0][MODE_LSB +: 2]))
      else $error("mode not forwarded");
   mirror_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (psel && !penable && hit1) |=> prdata[BIT_MIRROR] == $past(mir_q[1]))
      else $error("mirror bit wrong");
   polarity_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (cs_q[0][BLK_LSB +: 3] == BLK_NONE) |-> cmp_pin_o[0] == (cmp_raw[0] ^ cs_q[0][BIT_INVERT]))
      else $error("polarity wrong");
   external_interrupt_controller_line_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmp_external_interrupt_controller_o == expect_out)
      else $error("interrupt line output wrong");
   scaler_pwr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      scaler_enable_o == (cs_q[0][BIT_SCALER] | cs_q[1][BIT_SCALER]))
      else $error("scaler power not the OR of enables");
   enable_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmp_ctrl_o[1].comparator_on == cs_q[1][BIT_ON])
      else $error("enable not forwarded");
   locked_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      locked_wr0 |=> clean_ack ##1 $stable(cs_q[0]))
      else $error("locked write answered badly");

   // ==========================================================
   // Second word, mirror lag and field forwarding
   sequence locked_wr1;
      psel && !penable && pwrite && hit1 && cs_q[1][BIT_LOCK];
   endsequence
   sequence open_wr1;
      psel && penable && pwrite && pready && hit1 && !cs_q[1][BIT_LOCK];
   endsequence

   // Two flops of lag, so a read may trail a fast output edge
   mirror_sync_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ##2 mir_q == $past(final_out, 2))
      else $error("mirror lag wrong");
   mirror0_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (psel && !penable && hit0) |=> prdata[BIT_MIRROR] == $past(mir_q[0]))
      else $error("mirror bit 0 wrong");
   polarity1_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (cs_q[1][BLK_LSB +: 3] == BLK_NONE) |-> cmp_pin_o[1] == (cmp_raw[1] ^ cs_q[1][BIT_INVERT]))
      else $error("polarity 1 wrong");
   pin_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmp_pin_o == expect_out && cmp_timer_o == expect_out)
      else $error("pin or timer output wrong");
   mode1_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmp_ctrl_o[1].speed_power_mode == cs_q[1][MODE_LSB +: 2])
      else $error("mode 1 not forwarded");
   hyst_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmp_ctrl_o[0].hysteresis_level == cs_q[0][HYST_LSB +: 2])
      else $error("hysteresis not forwarded");
   enable0_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      cmp_ctrl_o[0].comparator_on == cs_q[0][BIT_ON])
      else $error("enable 0 not forwarded");
   bridge_pwr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      bridge_enable_o == (cs_q[0][BIT_BRIDGE] | cs_q[1][BIT_BRIDGE]))
      else $error("bridge power not the OR of enables");
   // Open write lands masked, lock bit included, in the next cycle
   open_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      open_wr1 |=> cs_q[1] == $past(pwdata & CS_WR_MASK))
      else $error("open write did not land");
   locked_write1_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      locked_wr1 |=> clean_ack ##1 $stable(cs_q[1]))
      else $error("locked write 1 answered badly");
endmodule : cmpc_top

// ===== sim/cmpc_partner.sv
`timescale 1ns/1ps
// ==========================================================
// Analogue core and timer blanking model
module cmpc_partner (
   input  wire logic [1:0][11:0] vplus_mv,
   input  wire logic [1:0][11:0] vminus_mv,
   input  wire logic [3:0]       blank_req,
   output logic      [1:0]       cmp_raw,
   output logic      [3:0]       blank_src
);
   // Ideal comparison; offset and hysteresis are not modelled
   // Input pins are taken as already set to analog mode by software
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cmp_raw[i] = vplus_mv[i] > vminus_mv[i];
      end
   end
   // Timer compare channels held as plain levels
   assign blank_src = blank_req;
endmodule : cmpc_partner

// ===== sim/cmpc_top_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Register, lock and output conditioning bench
module cmpc_top_tb;
   import cmpc_pkg::*;
   logic                  ref_clk = 1'b0;
   logic                  rstn, psel, penable, pwrite, pslverr, pready, er;
   logic [ADDR_W-1:0]     paddr;
   logic [31:0]           pwdata, prdata, rd;
   logic [1:0]            cmp_raw, cmp_pin_o, cmp_timer_o, cmp_external_interrupt_controller_o;
   logic [3:0]            blank_src, blank_req;
   logic [1:0][11:0]      vplus_mv, vminus_mv;
   cmpc_ctrl_t [1:0]      cmp_ctrl_o;
   logic                  scaler_enable_o, bridge_enable_o, ex;
   int                    checks = 0;
   int                    miscompares = 0;
`define CHK(nm, ex_v, gt) begin checks++; if ((gt) !== (ex_v)) begin miscompares++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex_v, gt); end end

   always #4 ref_clk = ~ref_clk;

   cmpc_top DUT (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_raw(cmp_raw), .blank_src(blank_src), .cmp_pin_o(cmp_pin_o),
      .cmp_timer_o(cmp_timer_o), .cmp_external_interrupt_controller_o(cmp_external_interrupt_controller_o), .cmp_ctrl_o(cmp_ctrl_o),
      .scaler_enable_o(scaler_enable_o), .bridge_enable_o(bridge_enable_o));
   cmpc_partner u_partner (.vplus_mv(vplus_mv), .vminus_mv(vminus_mv), .blank_req(blank_req),
      .cmp_raw(cmp_raw), .blank_src(blank_src));

   // Verdict and end of run
   task automatic test_done;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   // One word transfer; answer taken at the rising edge that sees pready high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge ref_clk) #1;
      psel = 1'b1; pwrite = w; paddr = a; pwdata = d; penable = 1'b0;
      @(posedge ref_clk) #1;
      penable = 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 8) begin
         @(posedge ref_clk);
         n++;
      end
      r = prdata;
      e = pslverr;
      `CHK("pready", 1'b1, pready)
      #1;
      psel = 1'b0; penable = 1'b0;
   endtask : apb

   // Selected blanking level for a code; reserved codes blank nothing
   function automatic logic sel_blk(input logic [2:0] c, input logic [3:0] b);
      return (c == 3'h1) ? b[0] : (c == 3'h2) ? b[1] : (c == 3'h4) ? b[2] :
             (c == 3'h5) ? b[3] : 1'b0;
   endfunction : sel_blk

   // Hang guard at 10000 cycles, far beyond the roughly 1600 cycles the tests need
   initial begin
      #80000;
      miscompares++;
      test_done();
   end

   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
      vplus_mv = '0; vminus_mv = '0; blank_req = '0; rstn = 0;
      repeat (5) @(posedge ref_clk);
      #1 rstn = 1;
      apb(0, OFS_CS0, 0, rd, er); `CHK("cs0 reset", CS_RESET, rd)
      apb(0, OFS_CS1, 0, rd, er); `CHK("cs1 reset", CS_RESET, rd)
      `CHK("hyst reset", HYST_OFF, cmp_ctrl_o[0].hysteresis_level)
      `CHK("mode reset", MODE_FAST, cmp_ctrl_o[0].speed_power_mode)
      // All writable bits but lock; invert flips a low result into a high mirror
      apb(1, OFS_CS0, 32'h7fff_ffff, rd, er);
      repeat (4) @(posedge ref_clk);
      apb(0, OFS_CS0, 0, rd, er); `CHK("cs0 mask", 32'h40df_887d, rd)
      `CHK("ctrl0", 9'h1ff, cmp_ctrl_o[0])
      `CHK("scaler", 2'h3, {scaler_enable_o, bridge_enable_o})
      for (int m = 0; m < 4; m++) begin
         apb(1, OFS_CS0, 32'(m) << MODE_LSB, rd, er);
         `CHK("mode", 2'(m), cmp_ctrl_o[0].speed_power_mode)
      end
      // Shared scaler stays on while either word asks for it
      apb(1, OFS_CS1, 32'h0080_0000, rd, er); `CHK("scaler or", 1'b1, scaler_enable_o)
      apb(1, OFS_CS1, 32'h0, rd, er); `CHK("scaler off", 1'b0, scaler_enable_o)
      // Every polarity, result, blanking code and timer level
      vminus_mv[1] = 12'h200;
      for (int inv = 0; inv < 2; inv++) begin
         for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 8; c++) begin
               for (int b = 0; b < 16; b++) begin
                  vplus_mv[1] = (r != 0) ? 12'h320 : 12'h100;
                  blank_req = 4'(b);
                  apb(1, OFS_CS1, (32'(c) << BLK_LSB) | (32'(inv) << BIT_INVERT), rd, er);
                  ex = (1'(r) ^ 1'(inv)) & ~sel_blk(3'(c), 4'(b));
                  `CHK("pin", ex, cmp_pin_o[1])
                  `CHK("timer", ex, cmp_timer_o[1])
                  `CHK("external_interrupt_controller", ex, cmp_external_interrupt_controller_o[1])
               end
            end
         end
      end
      vplus_mv[1] = 12'h100;
      repeat (4) @(posedge ref_clk);
      apb(0, OFS_CS1, 0, rd, er); `CHK("mirror1", 1'b1, rd[BIT_MIRROR])
      // Lock freezes the word and its own bit
      apb(1, OFS_CS0, 32'h8000_0001, rd, er);
      apb(1, OFS_CS0, 32'h0000_0000, rd, er); `CHK("lock ack", 1'b0, er)
      apb(0, OFS_CS0, 0, rd, er); `CHK("locked", 32'h8000_0001, rd)
      `CHK("locked on", 1'b1, cmp_ctrl_o[0].comparator_on)
      apb(0, 12'h008, 0, rd, er); `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 32'h0, rd)
      // Second word locks with its scaler on; the shared scaler must stay up
      apb(1, OFS_CS1, 32'h8080_0000, rd, er);
      apb(1, OFS_CS1, 32'h0000_0000, rd, er); `CHK("lock1 ack", 1'b0, er)
      apb(0, OFS_CS1, 0, rd, er); `CHK("locked1", 32'h8080_0000, rd)
      `CHK("locked scaler", 1'b1, scaler_enable_o)
      // Only a system reset releases the lock
      rstn = 0;
      repeat (5) @(posedge ref_clk);
      #1 rstn = 1;
      apb(0, OFS_CS0, 0, rd, er); `CHK("unlocked", CS_RESET, rd)
      apb(0, OFS_CS1, 0, rd, er); `CHK("unlocked1", CS_RESET, rd)
      `CHK("scaler reset", 1'b0, scaler_enable_o)
      test_done();
   end
endmodule : cmpc_top_tb
